/* File: common/smq_consts.svh */
// Constants for the status message queues: codes, flag positions, sizes.
// Assumes inclusion by bare name from the package and design files.
`ifndef SMQ_CONSTS_SVH
`define SMQ_CONSTS_SVH

// Queue sizes
`define SMQ_ERR_DEPTH        10
`define SMQ_ERR_CODE_W       16
`define SMQ_MSG_DEPTH        16
`define SMQ_MSG_W            8

// Status byte layout
`define SMQ_STB_W            8
`define SMQ_STB_ERR_BIT      2
`define SMQ_STB_MSG_BIT      4

// Error event inputs, one bit per cause
`define SMQ_NUM_EVT          27
`define SMQ_EVT_SYNTAX_LO    0
`define SMQ_EVT_NV_INVALID   5
`define SMQ_EVT_PAR_COMM     6
`define SMQ_EVT_DC_MODE      7
`define SMQ_EVT_SEQ_LO       8
`define SMQ_EVT_SEQ_HI       12
`define SMQ_EVT_SHDN_LO      13
`define SMQ_EVT_SHDN_HI      26

// Error codes
`define SMQ_CODE_NONE        16'sh0000
`define SMQ_CODE_CMD         -16'sd100
`define SMQ_CODE_MISS_PAR    -16'sd109
`define SMQ_CODE_PAR_COUNT   -16'sd115
`define SMQ_CODE_SUFFIX      -16'sd131
`define SMQ_CODE_STRING      -16'sd151
`define SMQ_CODE_OVERFLOW    -16'sd350
`define SMQ_CODE_NV_INVALID  16'sh0001
`define SMQ_CODE_PAR_COMM    16'sh0006
`define SMQ_CODE_DC_MODE     16'sh000B
`define SMQ_CODE_SEQ_BASE    16'sh0011
`define SMQ_CODE_SHDN_BASE   16'sh001E

`endif

/* File: common/smq_pkg.sv */
// Types shared by the status message queues.
// Assumes smq_consts.svh is on the include path.
`include "smq_consts.svh"

package smq_pkg;

    typedef logic signed [`SMQ_ERR_CODE_W-1:0] smq_code_type;

    // Answer to one error read query
    typedef struct packed {
        logic         empty;
        logic         overflow;
        smq_code_type code;
    } smq_err_answer_type;

    // Status byte flags driven by this block
    typedef struct packed {
        logic msg_available;
        logic err_available;
    } smq_flags_type;

endpackage

/* File: rtl/smq_fifo.sv */
// Flip-flop FIFO with clear and optional replace-newest-when-full.
// Assumes one clock, synchronous active-high reset.
module smq_fifo #(
    parameter int WIDTH           = 16,
    parameter int DEPTH           = 10,
    parameter bit REPLACE_ON_FULL = 1'b0,
    parameter int CW              = $clog2(DEPTH + 1)
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic [WIDTH-1:0] replace_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  full,
    output logic                  empty,
    output logic      [CW-1:0]    count
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        return (p == LAST) ? '0 : PW'(p + 1'b1);
    endfunction

    function automatic logic [PW-1:0] ptr_prev(input logic [PW-1:0] p);
        return (p == '0) ? LAST : PW'(p - 1'b1);
    endfunction

    wire do_pop     = pop & ~empty;
    wire do_push    = push & (~full | do_pop);
    wire do_replace = REPLACE_ON_FULL & push & full & ~do_pop;
    wire [CW-1:0] next_count = CW'(count + CW'(do_push) - CW'(do_pop));

    assign full  = (count == CW'(DEPTH));
    assign empty = (count == '0);
    assign head  = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                mem[wr_ptr] <= push_data;
                wr_ptr      <= ptr_next(wr_ptr);
            end
            // Newest slot, one behind the write pointer
            if (do_replace) begin
                mem[ptr_prev(wr_ptr)] <= replace_data;
            end
            if (do_pop) begin
                rd_ptr <= ptr_next(rd_ptr);
            end
            count <= next_count;
        end
    end
endmodule

/* File: rtl/smq_top.sv */
// Output queue and error queue for remote status reporting.
// Assumes one clock, synchronous reset at power-up, pulse-wide commands.
`include "smq_consts.svh"

module smq_top #(
    parameter int MSG_W     = `SMQ_MSG_W,
    parameter int MSG_DEPTH = `SMQ_MSG_DEPTH,
    parameter int ERR_DEPTH = `SMQ_ERR_DEPTH,
    parameter int NUM_EVT   = `SMQ_NUM_EVT,
    parameter int MCW       = $clog2(MSG_DEPTH + 1),
    parameter int ECW       = $clog2(ERR_DEPTH + 1)
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    input  wire logic                        cls_cmd,
    input  wire logic                        resp_valid,
    output logic                             resp_ready,
    input  wire logic [MSG_W-1:0]            resp_data,
    input  wire logic                        msg_read,
    output logic                             msg_valid,
    output logic      [MSG_W-1:0]            msg_data,
    output logic      [MCW-1:0]              msg_count,
    input  wire logic [NUM_EVT-1:0]          err_event,
    input  wire logic                        err_query,
    output logic                             err_answer_valid,
    output smq_pkg::smq_err_answer_type      err_answer,
    output logic      [ECW-1:0]              err_count,
    output logic                             apply_defaults,
    output logic      [`SMQ_STB_W-1:0]       status_byte
);

    // ------------------------------------------------------------------
    // Output queue
    // ------------------------------------------------------------------
    logic msg_full;
    logic msg_empty;

    wire msg_push = resp_valid & resp_ready;
    wire msg_pop  = msg_read & ~msg_empty;

    assign resp_ready = ~msg_full & ~cls_cmd;
    assign msg_valid  = ~msg_empty;

    // Messages stay stored until popped by a read
    smq_fifo #(
        .WIDTH           (MSG_W),
        .DEPTH           (MSG_DEPTH),
        .REPLACE_ON_FULL (1'b0),
        .CW              (MCW)
    ) u_msg_fifo (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .clear        (cls_cmd),
        .push         (msg_push),
        .push_data    (resp_data),
        .replace_data ('0),
        .pop          (msg_pop),
        .head         (msg_data),
        .full         (msg_full),
        .empty        (msg_empty),
        .count        (msg_count)
    );
    // Reset and clear-status both empty it above

    // ------------------------------------------------------------------
    // Error code mapping
    // ------------------------------------------------------------------
    function automatic smq_pkg::smq_code_type code_of(input int idx);
        smq_pkg::smq_code_type c;
        c = `SMQ_CODE_CMD;
        case (idx)
            0:       c = `SMQ_CODE_CMD;
            1:       c = `SMQ_CODE_MISS_PAR;
            2:       c = `SMQ_CODE_PAR_COUNT;
            3:       c = `SMQ_CODE_SUFFIX;
            4:       c = `SMQ_CODE_STRING;
            `SMQ_EVT_NV_INVALID:
                     c = `SMQ_CODE_NV_INVALID;
            `SMQ_EVT_PAR_COMM:
                     c = `SMQ_CODE_PAR_COMM;
            `SMQ_EVT_DC_MODE:
                     c = `SMQ_CODE_DC_MODE;
            default: begin
                if (idx >= `SMQ_EVT_SEQ_LO && idx <= `SMQ_EVT_SEQ_HI) begin
                    // Cause offset from the first sequencer code
                    c = `SMQ_CODE_SEQ_BASE + 16'(idx - `SMQ_EVT_SEQ_LO);
                end else if (idx >= `SMQ_EVT_SHDN_LO && idx <= `SMQ_EVT_SHDN_HI) begin
                    // One code per shutdown cause
                    c = `SMQ_CODE_SHDN_BASE + 16'(idx - `SMQ_EVT_SHDN_LO);
                end else begin
                    c = `SMQ_CODE_CMD;
                end
            end
        endcase
        return c;
    endfunction

    // Index of lowest set bit
    function automatic int lowest_index(input logic [NUM_EVT-1:0] v);
        int r;
        r = 0;
        for (int i = NUM_EVT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Pending events: one queued per cycle, lowest index first
    // ------------------------------------------------------------------
    logic [NUM_EVT-1:0] pending;
    logic [NUM_EVT-1:0] next_pending;

    wire                any_pending = |pending;
    wire [NUM_EVT-1:0]  grant       = pending & NUM_EVT'(~pending + 1'b1);
    int                 grant_idx;
    wire smq_pkg::smq_code_type grant_code = code_of(grant_idx);

    assign grant_idx = lowest_index(pending);

    // Arrival in the cycle of its grant or clear is kept
    genvar g;
    generate
        for (g = 0; g < NUM_EVT; g++) begin : g_pend
            assign next_pending[g] = err_event[g] |
                                     (pending[g] & ~grant[g] & ~cls_cmd);
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    // ------------------------------------------------------------------
    // Error queue
    // ------------------------------------------------------------------
    smq_pkg::smq_code_type err_head;
    logic                  err_full;
    logic                  err_empty;
    logic                  err_clear;

    wire err_push = any_pending & ~cls_cmd;
    wire err_pop  = err_query & ~err_empty & ~cls_cmd;

    // Empty answer ends a read-out and clears the queue
    // A push landing with the empty answer is kept
    assign err_clear = cls_cmd | (err_query & err_empty & ~err_push);

    // First in, first out, ten deep
    // Full push replaces the newest entry
    smq_fifo #(
        .WIDTH           (`SMQ_ERR_CODE_W),
        .DEPTH           (ERR_DEPTH),
        .REPLACE_ON_FULL (1'b1),
        .CW              (ECW)
    ) u_err_fifo (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .clear        (err_clear),
        .push         (err_push),
        .push_data    (grant_code),
        .replace_data (`SMQ_CODE_OVERFLOW),
        .pop          (err_pop),
        .head         (err_head),
        .full         (err_full),
        .empty        (err_empty),
        .count        (err_count)
    );

    // ------------------------------------------------------------------
    // Error query answer, one cycle after the query
    // ------------------------------------------------------------------
    smq_pkg::smq_err_answer_type next_answer;
    wire answer_now = err_query & ~cls_cmd;

    always_comb begin
        next_answer = '0;
        if (err_empty) begin
            // Nothing stored: code zero, no error
            next_answer.empty    = 1'b1;
            next_answer.overflow = 1'b0;
            next_answer.code     = `SMQ_CODE_NONE;
        end else begin
            // Signed code selects the quoted description
            next_answer.empty    = 1'b0;
            next_answer.overflow = (err_head == `SMQ_CODE_OVERFLOW);
            next_answer.code     = err_head;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_answer_valid <= 1'b0;
            err_answer       <= '0;
        end else begin
            err_answer_valid <= answer_now;
            if (answer_now) begin
                err_answer <= next_answer;
            end
        end
    end

    // ------------------------------------------------------------------
    // Defaults after invalid stored settings
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            apply_defaults <= 1'b0;
        end else begin
            apply_defaults <= err_event[`SMQ_EVT_NV_INVALID];
        end
    end

    // ------------------------------------------------------------------
    // Status byte flags
    // ------------------------------------------------------------------
    smq_pkg::smq_flags_type flags;
    logic [`SMQ_STB_W-1:0]  next_status;

    assign flags.msg_available = ~msg_empty;
    assign flags.err_available = ~err_empty;

    always_comb begin
        next_status                   = '0;
        next_status[`SMQ_STB_MSG_BIT] = flags.msg_available;
        next_status[`SMQ_STB_ERR_BIT] = flags.err_available;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_byte <= '0;
        end else begin
            status_byte <= next_status;
        end
    end

endmodule

/* File: tb/smq_top_asserts.sv */
// Checker for the status message queues, bound to smq_top.
// Assumes one clock and a synchronous active-high reset.
`include "smq_consts.svh"

module smq_top_asserts #(
    parameter int MSG_DEPTH = 16,
    parameter int ERR_DEPTH = 10,
    parameter int NUM_EVT   = 27,
    parameter int MCW       = 5,
    parameter int ECW       = 4
) (
    input wire logic                        clk_sys,
    input wire logic                        rst,
    input wire logic                        cls_cmd,
    input wire logic                        resp_ready,
    input wire logic                        msg_valid,
    input wire logic [MCW-1:0]              msg_count,
    input wire logic [NUM_EVT-1:0]          err_event,
    input wire logic                        err_query,
    input wire logic                        err_answer_valid,
    input wire smq_pkg::smq_err_answer_type err_answer,
    input wire logic [ECW-1:0]              err_count,
    input wire logic                        apply_defaults,
    input wire logic [`SMQ_STB_W-1:0]       status_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_query;
        err_query && !cls_cmd;
    endsequence
    sequence s_answer;
        err_answer_valid;
    endsequence

    property p_answer; s_query |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("query not answered");
    property p_no_answer; !err_query |=> !err_answer_valid; endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without query");
    property p_empty; s_query ##0 (err_count == 0) |=> s_answer ##0 (err_answer.empty && err_answer.code == 0);
    endproperty
    a_empty: assert property (p_empty) else $error("empty answer wrong");
    property p_found; s_query ##0 (err_count != 0) |=> !err_answer.empty; endproperty
    a_found: assert property (p_found) else $error("stored entry not returned");
    property p_err_max; err_count <= ERR_DEPTH; endproperty
    a_err_max: assert property (p_err_max) else $error("error queue over depth");
    property p_msg_flag; 1'b1 |=> status_byte[`SMQ_STB_MSG_BIT] == $past(msg_valid); endproperty
    a_msg_flag: assert property (p_msg_flag) else $error("message flag wrong");
    property p_err_flag; 1'b1 |=> status_byte[`SMQ_STB_ERR_BIT] == $past(err_count != 0); endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag wrong");
    property p_spare; (status_byte & 8'hEB) == 8'h00; endproperty
    a_spare: assert property (p_spare) else $error("spare status bit set");
    property p_cls; cls_cmd |=> msg_count == 0 && err_count == 0; endproperty
    a_cls: assert property (p_cls) else $error("clear left entries");
    property p_defaults; err_event[`SMQ_EVT_NV_INVALID] && !cls_cmd |=> apply_defaults; endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not applied");
    property p_full; msg_count == MSG_DEPTH |-> !resp_ready; endproperty
    a_full: assert property (p_full) else $error("push offered when full");
    property p_msg_valid; msg_valid == (msg_count != 0); endproperty
    a_msg_valid: assert property (p_msg_valid) else $error("message valid wrong");
endmodule

/* File: tb/smq_host.sv */
// Host computer model: pulls response bytes and asks for error reports.
// Assumes answers come one cycle after the query edge.
module smq_host (
    input  wire logic                        clk_sys,
    input  wire logic                        msg_valid,
    input  wire logic [7:0]                  msg_data,
    input  wire logic                        err_answer_valid,
    input  wire smq_pkg::smq_err_answer_type err_answer,
    output logic                             msg_read,
    output logic                             err_query
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        msg_read = 1'b0;
        err_query = 1'b0;
    end
    // Slow host when gap is nonzero
    task automatic read_msg(input int gap, output logic v, output logic [7:0] d);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        v = msg_valid;
        d = msg_data;
        msg_read <= 1'b1;
        @(posedge clk_sys);
        msg_read <= 1'b0;
    endtask
    task automatic query(output logic v, output smq_pkg::smq_err_answer_type a);
        @(posedge clk_sys);
        err_query <= 1'b1;
        @(posedge clk_sys);
        err_query <= 1'b0;
        @(posedge clk_sys);
        v = err_answer_valid;
        a = err_answer;
    endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the status message queues with a host model.
// Assumes package, header and rtl are compiled before this file.
`include "smq_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        clk_sys = 1'b0;
    logic                        rst = 1'b1;
    logic                        cls_cmd = 1'b0;
    logic                        resp_valid = 1'b0;
    logic [7:0]                  resp_data = 8'h00;
    logic [26:0]                 err_event = '0;
    logic                        resp_ready, msg_read, msg_valid, err_query, err_answer_valid, apply_defaults, ok, got;
    logic [7:0]                  msg_data, status_byte, d;
    logic [4:0]                  msg_count;
    logic [3:0]                  err_count;
    smq_pkg::smq_err_answer_type err_answer, ans;
    int                          miscompares = 0, compares = 0, cycles = 0, e;
    int                          eq[$];
    logic [7:0]                  mq[$];
    logic [31:0]                 seed = 32'h9bee_3d79;

    always #5 clk_sys = ~clk_sys;

    smq_top dut (.clk_sys(clk_sys), .rst(rst), .cls_cmd(cls_cmd), .resp_valid(resp_valid), .resp_ready(resp_ready),
        .resp_data(resp_data), .msg_read(msg_read), .msg_valid(msg_valid), .msg_data(msg_data),
        .msg_count(msg_count), .err_event(err_event), .err_query(err_query), .err_answer_valid(err_answer_valid),
        .err_answer(err_answer), .err_count(err_count), .apply_defaults(apply_defaults), .status_byte(status_byte));
    smq_host host (.clk_sys(clk_sys), .msg_valid(msg_valid), .msg_data(msg_data), .err_answer_valid(err_answer_valid),
        .err_answer(err_answer), .msg_read(msg_read), .err_query(err_query));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int code_of(input int i);
        int syn[5] = '{-100, -109, -115, -131, -151};
        if (i < 5) return syn[i];
        if (i < 8) return (i == 5) ? 1 : (i == 6) ? 6 : 11;
        return (i < 13) ? i + 9 : i + 17;
    endfunction
    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic fire(input int i);
        @(posedge clk_sys);
        err_event <= 27'(1) << i;
        @(posedge clk_sys);
        err_event <= '0;
        if (eq.size() == 10) eq[9] = -350;
        else eq.push_back(code_of(i));
        @(posedge clk_sys);
        chk(apply_defaults === (i == `SMQ_EVT_NV_INVALID), "defaults pulse");
    endtask
    task automatic push(input logic [7:0] v, output logic acc);
        @(posedge clk_sys);
        resp_valid <= 1'b1;
        resp_data <= v;
        acc = 1'b0;
        for (int k = 0; k < 3 && !acc; k++) begin
            @(posedge clk_sys);
            acc = resp_ready;
        end
        resp_valid <= 1'b0;
    endtask
    // Read every stored report, then one more for the empty answer
    task automatic drain();
        int n;
        repeat (4) @(posedge clk_sys);
        chk(err_count === 4'(eq.size()), "error count");
        chk(status_byte[`SMQ_STB_ERR_BIT] === (eq.size() != 0), "error flag");
        n = eq.size();
        for (int k = 0; k <= n; k++) begin
            host.query(got, ans);
            if (eq.size() == 0) chk(got === 1'b1 && ans.empty === 1'b1 && ans.code === 16'sh0000, "empty");
            else begin
                e = eq.pop_front();
                chk(got === 1'b1 && ans.empty === 1'b0 && ans.code === 16'(e), "error answer");
                chk(ans.overflow === (e == -350), "overflow mark");
            end
        end
        repeat (2) @(posedge clk_sys);
        chk(err_count === 4'h0 && status_byte[`SMQ_STB_ERR_BIT] === 1'b0, "read-out clear");
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(status_byte === 8'h00 && resp_ready === 1'b1 && msg_valid === 1'b0, "reset state");
        drain();
        for (int i = 0; i < 27; i++) begin
            fire(i);
            if (eq.size() == 9 || i == 26) drain();
        end
        for (int i = 0; i < 13; i++) begin
            seed = lfsr(seed);
            fire(int'(seed % 27));
        end
        drain();
        for (int i = 0; i < 17; i++) begin
            seed = lfsr(seed);
            push(seed[7:0], ok);
            chk(ok === (mq.size() < 16), "push accept");
            if (ok) mq.push_back(seed[7:0]);
        end
        chk(status_byte[`SMQ_STB_MSG_BIT] === 1'b1, "message flag");
        while (mq.size() != 0) begin
            seed = lfsr(seed);
            host.read_msg(int'(seed[1:0]), got, d);
            chk(got === 1'b1 && d === mq.pop_front(), "message order");
        end
        repeat (2) @(posedge clk_sys);
        chk(msg_valid === 1'b0 && status_byte === 8'h00, "queues idle");
        for (int i = 0; i < 3; i++) push(8'(i), ok);
        fire(7);
        fire(5);
        repeat (3) @(posedge clk_sys);
        cls_cmd <= 1'b1;
        @(posedge clk_sys);
        cls_cmd <= 1'b0;
        eq.delete();
        repeat (2) @(posedge clk_sys);
        chk(msg_count === 5'h00 && err_count === 4'h0 && status_byte === 8'h00, "clear status");
        drain();
        // Empty answer in the very cycle a new report is queued
        fork
            fire(7);
            begin
                @(posedge clk_sys);
                host.query(got, ans);
            end
        join
        chk(got === 1'b1 && ans.empty === 1'b1, "empty with arrival");
        drain();
        close_out();
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            close_out();
        end
    end
endmodule

bind smq_top smq_top_asserts #(.MSG_DEPTH(MSG_DEPTH), .ERR_DEPTH(ERR_DEPTH), .NUM_EVT(NUM_EVT), .MCW(MCW), .ECW(ECW))
    u_chk (.clk_sys(clk_sys), .rst(rst), .cls_cmd(cls_cmd), .resp_ready(resp_ready), .msg_valid(msg_valid),
    .msg_count(msg_count), .err_event(err_event), .err_query(err_query), .err_answer_valid(err_answer_valid),
    .err_answer(err_answer), .err_count(err_count), .apply_defaults(apply_defaults), .status_byte(status_byte));
